// >>> rtl/sideband_cmd_frame_init_state.sv
`timescale 1ns/1ps
`include "sideband_defs.svh"
// Operation
// [RULE1] Every supported command type yields a response frame in the response layout.
// [RULE2] Accept command frames: all-ones destination, header fields, checksum, padding, FCS.
// [RULE3] Responses carry all-ones addresses, response type, echoed IDs, response and reason codes.
// [RULE4] In initial state, every command other than acknowledge is answered with initialization-required reason code.
// [RULE5] Acknowledge command in initial state ends initial state; normal processing resumes.
// [RULE6] Acknowledge command always clears retry tracking; later instance IDs count as new.
// [RULE7] Acknowledge command is type 0x00 with no payload; checksum then padding.
// [RULE8] Acknowledge response is type 0x80 with response and reason codes, no special reason.
// [RULE9] Command types lie in 0x00..0x7F; response type is command type with MSB set.
// [RULE10] Frames with wrong protocol type or header revision are dropped without response.
module sideband_cmd_frame_init_state #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sysClk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxLast,
  output logic rxReady,
  input wire logic enterInit,
  output logic [7:0] txData,
  output logic txValid,
  output logic txLast,
  input wire logic txReady,
  output logic initState,
  output logic retryHit,
  output logic frameDropped
);
  import sideband_pkg::*;

  frame_state_type state_ff, nxt_state;
  logic [5:0] rxCnt_ff, nxt_rxCnt;
  logic [5:0] txCnt_ff, nxt_txCnt;
  logic destOk_ff, nxt_destOk;
  byte_type etypeHi_ff, nxt_etypeHi;
  byte_type etypeLo_ff, nxt_etypeLo;
  byte_type mgrId_ff, nxt_mgrId;
  byte_type hdrRev_ff, nxt_hdrRev;
  byte_type iid_ff, nxt_iid;
  byte_type cmdType_ff, nxt_cmdType;
  byte_type chanId_ff, nxt_chanId;
  logic initState_ff, nxt_initState;
  byte_type lastIid_ff, nxt_lastIid;
  logic lastIidValid_ff, nxt_lastIidValid;
  logic [15:0] respCode_ff, nxt_respCode;
  logic [15:0] reasonCode_ff, nxt_reasonCode;
  logic retryHit_ff, nxt_retryHit;
  logic dropped_ff, nxt_dropped;
  logic rxTake, frameEnd, frameGood, frameAccept, isClear;
  byte_type respByte;

  byte_stream_if #(.WIDTH(9)) pushBus ();
  byte_stream_if #(.WIDTH(9)) popBus ();

  assign rxReady = (state_ff == RECEIVE);
  assign rxTake = rxValid && rxReady;
  assign frameEnd = rxTake && rxLast;
  // Header must be complete through the channel field before a frame counts
  assign frameGood = destOk_ff && ({etypeHi_ff, etypeLo_ff} == `ETYPE_VALUE) // RULE2
    && (hdrRev_ff == `HDR_REV_VALUE) // RULE10
    && (cmdType_ff <= `CMD_TYPE_MAX) // RULE9
    && (rxCnt_ff > `OFS_CHAN_ID);
  assign frameAccept = frameEnd && frameGood;
  assign isClear = (cmdType_ff == `CMD_CLEAR_INIT); // RULE7

  // Response frame contents, one byte per index
  always_comb begin
    respByte = 8'h00;
    if (txCnt_ff <= `OFS_SRC_LAST) begin
      respByte = `ADDR_ALL_ONES; // RULE3
    end else if (txCnt_ff == `OFS_ETYPE_HI) begin
      respByte = 8'(`ETYPE_VALUE >> 8);
    end else if (txCnt_ff == `OFS_ETYPE_LO) begin
      respByte = 8'(`ETYPE_VALUE);
    end else if (txCnt_ff == `OFS_MGR_ID) begin
      respByte = mgrId_ff;
    end else if (txCnt_ff == `OFS_HDR_REV) begin
      respByte = hdrRev_ff;
    end else if (txCnt_ff == `OFS_IID) begin
      respByte = iid_ff; // RULE3
    end else if (txCnt_ff == `OFS_CMD_TYPE) begin
      respByte = cmdType_ff | `RESP_TYPE_BIT; // RULE9
    end else if (txCnt_ff == `OFS_CHAN_ID) begin
      respByte = chanId_ff; // RULE3
    end else if (txCnt_ff == `OFS_PLEN_LO) begin
      respByte = `RESP_PLEN;
    end else if (txCnt_ff == `OFS_RESP_HI) begin
      respByte = respCode_ff[15:8];
    end else if (txCnt_ff == `OFS_RESP_LO) begin
      respByte = respCode_ff[7:0];
    end else if (txCnt_ff == `OFS_REASON_HI) begin
      respByte = reasonCode_ff[15:8];
    end else if (txCnt_ff == `OFS_REASON_LO) begin
      respByte = reasonCode_ff[7:0];
    end
  end

  assign pushBus.valid = (state_ff == EMIT); // RULE1
  assign pushBus.data = {txCnt_ff == `OFS_FRAME_LAST, respByte};

  always_comb begin
    nxt_state = state_ff;
    nxt_rxCnt = rxCnt_ff;
    nxt_txCnt = txCnt_ff;
    nxt_destOk = destOk_ff;
    nxt_etypeHi = etypeHi_ff;
    nxt_etypeLo = etypeLo_ff;
    nxt_mgrId = mgrId_ff;
    nxt_hdrRev = hdrRev_ff;
    nxt_iid = iid_ff;
    nxt_cmdType = cmdType_ff;
    nxt_chanId = chanId_ff;
    nxt_initState = initState_ff;
    nxt_lastIid = lastIid_ff;
    nxt_lastIidValid = lastIidValid_ff;
    nxt_respCode = respCode_ff;
    nxt_reasonCode = reasonCode_ff;
    nxt_retryHit = 1'b0;
    nxt_dropped = 1'b0;
    case (state_ff)
      RECEIVE: begin
        if (frameEnd) begin
          nxt_rxCnt = '0;
          nxt_destOk = 1'b1;
          if (frameGood) begin
            nxt_state = EMIT;
            nxt_txCnt = '0;
            if (isClear) begin
              nxt_initState = 1'b0; // RULE5
              nxt_lastIidValid = 1'b0; // RULE6
              nxt_respCode = `RC_COMPLETED; // RULE8
              nxt_reasonCode = `REASON_NONE;
            end else if (initState_ff) begin
              nxt_respCode = `RC_FAILED; // RULE4
              nxt_reasonCode = `REASON_INIT_REQ;
            end else begin
              nxt_retryHit = lastIidValid_ff && (lastIid_ff == iid_ff);
              nxt_lastIid = iid_ff;
              nxt_lastIidValid = 1'b1;
              nxt_respCode = `RC_FAILED;
              nxt_reasonCode = `REASON_UNSUPPORTED;
            end
          end else begin
            nxt_dropped = 1'b1; // RULE10
          end
        end else if (rxTake) begin
          if (rxCnt_ff != `OFS_FRAME_LAST) begin
            nxt_rxCnt = 6'(rxCnt_ff + 1'b1);
          end
          if (rxCnt_ff <= `OFS_DEST_LAST && rxData != `ADDR_ALL_ONES) begin
            nxt_destOk = 1'b0; // RULE2
          end
          if (rxCnt_ff == `OFS_ETYPE_HI) nxt_etypeHi = rxData;
          if (rxCnt_ff == `OFS_ETYPE_LO) nxt_etypeLo = rxData;
          if (rxCnt_ff == `OFS_MGR_ID) nxt_mgrId = rxData;
          if (rxCnt_ff == `OFS_HDR_REV) nxt_hdrRev = rxData;
          if (rxCnt_ff == `OFS_IID) nxt_iid = rxData;
          if (rxCnt_ff == `OFS_CMD_TYPE) nxt_cmdType = rxData;
          if (rxCnt_ff == `OFS_CHAN_ID) nxt_chanId = rxData;
        end
      end
      EMIT: begin
        if (pushBus.ready) begin
          nxt_txCnt = 6'(txCnt_ff + 1'b1);
          if (txCnt_ff == `OFS_FRAME_LAST) begin
            nxt_state = RECEIVE;
          end
        end
      end
      default: nxt_state = RECEIVE;
    endcase
    // An outside request to re-enter the initial state wins over a clear
    if (enterInit) begin
      nxt_initState = 1'b1;
    end
  end

  always_ff @(posedge sysClk) begin
    if (srst) begin
      state_ff <= RECEIVE;
      rxCnt_ff <= '0;
      txCnt_ff <= '0;
      destOk_ff <= 1'b1;
      etypeHi_ff <= 8'h00;
      etypeLo_ff <= 8'h00;
      mgrId_ff <= 8'h00;
      hdrRev_ff <= 8'h00;
      iid_ff <= 8'h00;
      cmdType_ff <= 8'h00;
      chanId_ff <= 8'h00;
      initState_ff <= `RST_INIT_STATE;
      lastIid_ff <= 8'h00;
      lastIidValid_ff <= 1'b0;
      respCode_ff <= 16'h0000;
      reasonCode_ff <= 16'h0000;
      retryHit_ff <= 1'b0;
      dropped_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      rxCnt_ff <= nxt_rxCnt;
      txCnt_ff <= nxt_txCnt;
      destOk_ff <= nxt_destOk;
      etypeHi_ff <= nxt_etypeHi;
      etypeLo_ff <= nxt_etypeLo;
      mgrId_ff <= nxt_mgrId;
      hdrRev_ff <= nxt_hdrRev;
      iid_ff <= nxt_iid;
      cmdType_ff <= nxt_cmdType;
      chanId_ff <= nxt_chanId;
      initState_ff <= nxt_initState;
      lastIid_ff <= nxt_lastIid;
      lastIidValid_ff <= nxt_lastIidValid;
      respCode_ff <= nxt_respCode;
      reasonCode_ff <= nxt_reasonCode;
      retryHit_ff <= nxt_retryHit;
      dropped_ff <= nxt_dropped;
    end
  end

  resp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sysClk(sysClk),
    .srst(srst),
    .ce(ce),
    .inBus(pushBus),
    .outBus(popBus)
  );

  assign txValid = popBus.valid;
  assign txData = popBus.data[7:0];
  assign txLast = popBus.data[8];
  assign popBus.ready = txReady && ce;
  assign initState = initState_ff;
  assign retryHit = retryHit_ff;
  assign frameDropped = dropped_ff;

  init_refuse_a: assert property (@(posedge sysClk) disable iff (srst) // RULE4
    ce && frameAccept && !isClear && initState_ff && !enterInit
    |=> reasonCode_ff == `REASON_INIT_REQ && respCode_ff == `RC_FAILED && initState_ff)
    else $error("initial state command not refused");
  clear_exit_a: assert property (@(posedge sysClk) disable iff (srst) // RULE5
    ce && frameAccept && isClear && !enterInit |=> !initState_ff && reasonCode_ff == `REASON_NONE)
    else $error("acknowledge did not leave initial state");
  retry_reset_a: assert property (@(posedge sysClk) disable iff (srst) // RULE6
    ce && frameAccept && isClear |=> !lastIidValid_ff)
    else $error("retry tracking not cleared");
  resp_type_a: assert property (@(posedge sysClk) disable iff (srst) // RULE9
    pushBus.valid && txCnt_ff == `OFS_CMD_TYPE |-> pushBus.data[7:0] == (cmdType_ff | `RESP_TYPE_BIT))
    else $error("response type lacks top bit");
  dest_ones_a: assert property (@(posedge sysClk) disable iff (srst) // RULE3
    pushBus.valid && txCnt_ff <= `OFS_SRC_LAST |-> pushBus.data[7:0] == `ADDR_ALL_ONES)
    else $error("response address not all ones");
  bad_drop_a: assert property (@(posedge sysClk) disable iff (srst) // RULE10
    ce && frameEnd && !frameGood |=> state_ff == RECEIVE && frameDropped)
    else $error("bad frame not dropped");
  frame_start_a: assert property (@(posedge sysClk) disable iff (srst) // RULE1
    ce && frameAccept |=> pushBus.valid && txCnt_ff == 6'h00 && !rxReady)
    else $error("accepted frame gave no response");
  frame_end_a: assert property (@(posedge sysClk) disable iff (srst) // RULE1
    ce && pushBus.valid && pushBus.ready && txCnt_ff == `OFS_FRAME_LAST
    |-> pushBus.data[8] ##1 state_ff == RECEIVE)
    else $error("response frame length wrong");
endmodule : sideband_cmd_frame_init_state

// >>> rtl/sideband_defs.svh
`ifndef SIDEBAND_DEFS_SVH
`define SIDEBAND_DEFS_SVH

// Byte offsets inside a minimum-sized frame
`define OFS_DEST_LAST 6'h05
`define OFS_SRC_LAST 6'h0B
`define OFS_ETYPE_HI 6'h0C
`define OFS_ETYPE_LO 6'h0D
`define OFS_MGR_ID 6'h0E
`define OFS_HDR_REV 6'h0F
`define OFS_IID 6'h11
`define OFS_CMD_TYPE 6'h12
`define OFS_CHAN_ID 6'h13
`define OFS_PLEN_LO 6'h15
`define OFS_RESP_HI 6'h1E
`define OFS_RESP_LO 6'h1F
`define OFS_REASON_HI 6'h20
`define OFS_REASON_LO 6'h21
`define OFS_FRAME_LAST 6'h3F

// Field values
`define ADDR_ALL_ONES 8'hFF
`define ETYPE_VALUE 16'h88F8
`define HDR_REV_VALUE 8'h01
`define CMD_CLEAR_INIT 8'h00
`define CMD_TYPE_MAX 8'h7F
`define RESP_TYPE_BIT 8'h80
`define RESP_PLEN 8'h04

// Response and reason codes
`define RC_COMPLETED 16'h0000
`define RC_FAILED 16'h0001
`define REASON_NONE 16'h0000
`define REASON_INIT_REQ 16'h0001
`define REASON_UNSUPPORTED 16'h0003

// Reset values
`define RST_INIT_STATE 1'b1

`endif

// >>> rtl/sideband_pkg.sv
package sideband_pkg;
  typedef enum logic {
    RECEIVE,
    EMIT
  } frame_state_type;
  typedef logic [7:0] byte_type;
endpackage : sideband_pkg

// >>> rtl/byte_stream_if.sv
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 9);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// >>> rtl/resp_fifo.sv
`timescale 1ns/1ps
module resp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic sysClk,
  input wire logic srst,
  input wire logic ce,
  byte_stream_if.snk inBus,
  byte_stream_if.src outBus
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wrPtr_ff, nxt_wrPtr;
  logic [PW-1:0] rdPtr_ff, nxt_rdPtr;
  logic [PW:0] count_ff, nxt_count;
  logic doPush, doPop;

  assign inBus.ready = (count_ff != (PW+1)'(DEPTH));
  assign outBus.valid = (count_ff != '0);
  assign outBus.data = mem_ff[rdPtr_ff];
  assign doPush = inBus.valid && inBus.ready;
  assign doPop = outBus.valid && outBus.ready;

  always_comb begin
    nxt_wrPtr = doPush ? PW'(wrPtr_ff + 1'b1) : wrPtr_ff;
    nxt_rdPtr = doPop ? PW'(rdPtr_ff + 1'b1) : rdPtr_ff;
    nxt_count = count_ff;
    if (doPush && !doPop) begin
      nxt_count = (PW+1)'(count_ff + 1'b1);
    end else if (doPop && !doPush) begin
      nxt_count = (PW+1)'(count_ff - 1'b1);
    end
  end

  always_ff @(posedge sysClk) begin
    if (srst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else if (ce) begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end

  genvar i;
  for (i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge sysClk) begin
      if (ce && doPush && wrPtr_ff == PW'(i)) begin
        mem_ff[i] <= inBus.data;
      end
    end
  end

  full_blocks_a: assert property (@(posedge sysClk) disable iff (srst)
    count_ff == (PW+1)'(DEPTH) |-> !inBus.ready)
    else $error("fifo accepts while full");
  empty_quiet_a: assert property (@(posedge sysClk) disable iff (srst)
    count_ff == '0 |-> !outBus.valid)
    else $error("fifo offers data while empty");
  hold_data_a: assert property (@(posedge sysClk) disable iff (srst) // RULE3
    outBus.valid && !outBus.ready |=> outBus.valid && $stable(outBus.data))
    else $error("fifo output changed while stalled");
endmodule : resp_fifo

// >>> dv/mgmt_ctrl_model.sv
`timescale 1ns/1ps
module mgmt_ctrl_model (
  input wire logic sysClk,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic rxLast,
  input wire logic rxReady,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txLast,
  output logic txReady
);
  import sideband_pkg::*;
  byte_type resp [64];
  int respCount = 0;
  int lastIdx = -1;
  int cyc = 0;
  logic stall = 1'b0;
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    rxLast = 1'b0;
    txReady = 1'b0;
  end
  // Sink holds off every third cycle while stalling
  always @(posedge sysClk) begin
    cyc <= cyc + 1;
    txReady <= !(stall && (cyc % 3 == 0));
    if (txValid && txReady && respCount < 64) begin
      resp[respCount] <= txData;
      respCount <= respCount + 1;
      if (txLast) lastIdx <= respCount;
    end
  end
  // Bad: 1 destination, 2 protocol type, 3 header revision, 4 short frame
  task automatic sendFrame(input byte_type cmd, input byte_type instance_identifier, input byte_type chan, input int bad);
    byte_type b;
    int n;
    respCount <= 0;
    lastIdx <= -1;
    for (int i = 0; i < ((bad == 4) ? 16 : 64); i++) begin
      case (i)
        0, 1, 2, 3, 4, 5: b = (bad == 1 && i == 0) ? 8'h00 : 8'hFF;
        12: b = (bad == 2) ? 8'h89 : 8'h88;
        13: b = 8'hF8;
        14: b = 8'h21;
        15: b = (bad == 3) ? 8'h02 : 8'h01;
        17: b = instance_identifier;
        18: b = cmd;
        19: b = chan;
        default: b = (i > 5 && i < 12) ? 8'h02 + 8'(i) : 8'h00;
      endcase
      rxData <= b;
      rxValid <= 1'b1;
      rxLast <= (i == ((bad == 4) ? 15 : 63));
      n = 0;
      @(posedge sysClk);
      while (!rxReady && n < 500) begin
        @(posedge sysClk);
        n++;
      end
    end
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    rxData <= ~b;
  endtask : sendFrame
endmodule : mgmt_ctrl_model

// >>> dv/sideband_cmd_frame_init_state_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin errorCnt++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module sideband_cmd_frame_init_state_tb;
  import sideband_pkg::*;
  logic sysClk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic enterInit = 1'b0;
  logic [7:0] rxData, txData;
  logic rxValid, rxLast, rxReady, txValid, txLast, txReady, initState, retryHit, frameDropped;
  int errorCnt = 0;
  int checkCount = 0;
  int retryCnt = 0;
  int dropCnt = 0;
  int cycles = 0;
  always #12.5 sysClk = ~sysClk;
  sideband_cmd_frame_init_state i_sideband_cmd_frame_init_state (.sysClk(sysClk), .srst(srst), .ce(ce),
    .rxData(rxData), .rxValid(rxValid), .rxLast(rxLast), .rxReady(rxReady), .enterInit(enterInit),
    .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady), .initState(initState),
    .retryHit(retryHit), .frameDropped(frameDropped));
  mgmt_ctrl_model i_mgmt_ctrl_model (.sysClk(sysClk), .rxData(rxData), .rxValid(rxValid), .rxLast(rxLast),
    .rxReady(rxReady), .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady));
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (retryHit === 1'b1) retryCnt <= retryCnt + 1;
    if (frameDropped === 1'b1) dropCnt <= dropCnt + 1;
    if (cycles == 20000) begin
      errorCnt++;
      results();
    end
  end
  task automatic results();
    $display("Checks %0d, errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic checkResp(input byte_type cmd, input byte_type instance_identifier, input byte_type chan,
                           input logic [15:0] rc, input logic [15:0] reason);
    int n = 0;
    while (i_mgmt_ctrl_model.respCount < 64 && n < 1000) begin
      @(posedge sysClk);
      n++;
    end
    `CHK(i_mgmt_ctrl_model.respCount, 64)
    `CHK(i_mgmt_ctrl_model.lastIdx, 63)
    for (int i = 0; i < 12; i++) `CHK(i_mgmt_ctrl_model.resp[i], 8'hFF)
    `CHK({i_mgmt_ctrl_model.resp[12], i_mgmt_ctrl_model.resp[13]}, 16'h88F8)
    `CHK({i_mgmt_ctrl_model.resp[14], i_mgmt_ctrl_model.resp[15]}, 16'h2101)
    `CHK(i_mgmt_ctrl_model.resp[16], 8'h00)
    for (int i = 20; i < 30; i++) `CHK(i_mgmt_ctrl_model.resp[i], (i == 21) ? 8'h04 : 8'h00)
    for (int i = 34; i < 64; i++) `CHK(i_mgmt_ctrl_model.resp[i], 8'h00)
    `CHK(i_mgmt_ctrl_model.resp[17], instance_identifier)
    `CHK(i_mgmt_ctrl_model.resp[18], cmd | 8'h80)
    `CHK(i_mgmt_ctrl_model.resp[19], chan)
    `CHK({i_mgmt_ctrl_model.resp[30], i_mgmt_ctrl_model.resp[31]}, rc)
    `CHK({i_mgmt_ctrl_model.resp[32], i_mgmt_ctrl_model.resp[33]}, reason)
  endtask : checkResp
  task automatic initRefuse();
    `CHK(initState, 1'b1)
    i_mgmt_ctrl_model.sendFrame(8'h05, 8'h01, 8'h00, 0);
    checkResp(8'h05, 8'h01, 8'h00, 16'h0001, 16'h0001);
  endtask : initRefuse
  task automatic ackLeaves();
    i_mgmt_ctrl_model.sendFrame(8'h00, 8'h02, 8'h00, 0);
    checkResp(8'h00, 8'h02, 8'h00, 16'h0000, 16'h0000);
    `CHK(initState, 1'b0)
  endtask : ackLeaves
  task automatic retryTrack();
    i_mgmt_ctrl_model.stall <= 1'b1;
    i_mgmt_ctrl_model.sendFrame(8'h7F, 8'h09, 8'h01, 0);
    checkResp(8'h7F, 8'h09, 8'h01, 16'h0001, 16'h0003);
    i_mgmt_ctrl_model.sendFrame(8'h7F, 8'h09, 8'h01, 0);
    checkResp(8'h7F, 8'h09, 8'h01, 16'h0001, 16'h0003);
    `CHK(retryCnt, 1)
    i_mgmt_ctrl_model.sendFrame(8'h00, 8'h0A, 8'h01, 0);
    checkResp(8'h00, 8'h0A, 8'h01, 16'h0000, 16'h0000);
    i_mgmt_ctrl_model.sendFrame(8'h7F, 8'h09, 8'h01, 0);
    checkResp(8'h7F, 8'h09, 8'h01, 16'h0001, 16'h0003);
    `CHK(retryCnt, 1)
    i_mgmt_ctrl_model.stall <= 1'b0;
  endtask : retryTrack
  task automatic dropBad();
    for (int k = 1; k < 5; k++) begin
      i_mgmt_ctrl_model.sendFrame(8'h05, 8'h03, 8'h00, k);
      repeat (6) @(posedge sysClk);
    end
    i_mgmt_ctrl_model.sendFrame(8'h80, 8'h03, 8'h00, 0);
    repeat (6) @(posedge sysClk);
    `CHK(dropCnt, 5)
    `CHK(i_mgmt_ctrl_model.respCount, 0)
  endtask : dropBad
  task automatic reenter();
    // Frozen clock enable must hold the initial-state flag
    ce <= 1'b0;
    enterInit <= 1'b1;
    repeat (3) @(posedge sysClk);
    `CHK(initState, 1'b0)
    ce <= 1'b1;
    @(posedge sysClk);
    enterInit <= 1'b0;
    @(posedge sysClk);
    `CHK(initState, 1'b1)
    i_mgmt_ctrl_model.sendFrame(8'h7F, 8'h0B, 8'h02, 0);
    checkResp(8'h7F, 8'h0B, 8'h02, 16'h0001, 16'h0001);
  endtask : reenter
  initial begin
    repeat (8) @(posedge sysClk);
    srst <= 1'b0;
    @(posedge sysClk);
    initRefuse();
    ackLeaves();
    retryTrack();
    dropBad();
    reenter();
    results();
  end
endmodule : sideband_cmd_frame_init_state_tb
